// >>> design/uart_pkg.sv
// package: register selects, field positions, reset values and shared types of the uart
// assumes: one 40 MHz clock, 16-bit cpu data path
package uart_pkg;
	localparam logic [1:0] SEL_BAUD = 2'h0;
	localparam logic [1:0] SEL_TX = 2'h1;
	localparam logic [1:0] SEL_RX_STATUS = 2'h2;
	localparam logic [1:0] SEL_RX_BUFFER = 2'h3;
	localparam logic [15:0] BAUD_RESET = 16'h01AF;
	localparam int TX_READY_BIT = 8;
	localparam int RX_FULL_BIT = 8;
	localparam int FLOW_BIT = 0;
	localparam logic [3:0] FRAME_BITS = 4'hB;
	localparam logic [3:0] RX_BITS = 4'h9;
	localparam logic [15:0] READ_IDLE = 16'hFFFF;

	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [1:0] addr;
		logic [15:0] wdata;
	} cpu_req_type;

	typedef struct packed {
		logic ready;
		logic rx_full;
		logic flow;
		logic [7:0] rx_data;
	} status_type;

	function automatic logic [15:0] read_mux(input logic [1:0] addr, input logic [15:0] baud,
			input status_type st);
		logic [15:0] r;
		r = 16'h0000;
		case (addr)
			SEL_BAUD: r = baud;
			SEL_TX: r[TX_READY_BIT] = st.ready;
			SEL_RX_STATUS: begin
				r[RX_FULL_BIT] = st.rx_full;
				r[FLOW_BIT] = st.flow;
			end
			default: r = {8'h00, st.rx_data};
		endcase
		return r;
	endfunction
endpackage

// >>> design/uart_tx_core.sv
// transmit core: bit timing, bit count and serial line
// assumes: frame register and request are held in the register file
`timescale 1ns/1ps
module uart_tx_core
	import uart_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// control
	input wire logic [15:0] baud_i,
	input wire logic request_i,
	input wire logic cts_ok_i,
	input wire logic frame_lsb_i,
	// status and line
	output logic active_o,
	output logic shift_o,
	output logic txd_o,
	output logic irq_o
);
	logic [15:0] count;
	logic [3:0] bits;
	logic [15:0] next_count;
	logic [3:0] next_bits;
	logic next_active;
	logic next_shift;
	logic next_txd;
	logic next_irq;

	always_comb begin
		next_count = count;
		next_bits = bits;
		next_active = active_o;
		next_shift = 1'b0;
		next_txd = txd_o;
		next_irq = 1'b0;
		if (!active_o && request_i && cts_ok_i) begin
			next_count = baud_i;
			next_bits = FRAME_BITS;
			next_active = 1'b1;
		end else if (active_o) begin
			if (count != 16'h0000) begin
				next_count = count - 16'h0001;
			end else if (bits != 4'h0) begin
				next_bits = bits - 4'h1;
				next_txd = frame_lsb_i;
				next_shift = 1'b1;
				next_count = baud_i;
			end else begin
				next_txd = 1'b1;
				next_irq = 1'b1;
				next_active = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			count <= 16'h0000;
			bits <= 4'h0;
			active_o <= 1'b0;
			shift_o <= 1'b0;
			txd_o <= 1'b1;
			irq_o <= 1'b0;
		end else begin
			count <= next_count;
			bits <= next_bits;
			active_o <= next_active;
			shift_o <= next_shift;
			txd_o <= next_txd;
			irq_o <= next_irq;
		end
	end

	sequence bit_end_s;
		active_o && count == 16'h0000 && bits != 4'h0;
	endsequence

	start_load_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(!active_o && request_i && cts_ok_i) |=> active_o && bits == FRAME_BITS)
		else $error("transmit start did not load");
	bit_shift_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		bit_end_s |=> shift_o && txd_o == $past(frame_lsb_i) && count == $past(baud_i))
		else $error("bit edge wrong");
	count_down_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(active_o && count != 16'h0000) |=> count == $past(count) - 16'h0001)
		else $error("bit timer not counting");
	frame_end_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(active_o && count == 16'h0000 && bits == 4'h0) |=> irq_o && txd_o && !active_o
		##1 !irq_o)
		else $error("frame end wrong");
	shift_pulse_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		shift_o |=> !shift_o)
		else $error("shift longer than one clock");
endmodule

// >>> design/uart_rx_core.sv
// receive core: start detect, mid-bit sampling, buffer and full flag
// assumes: rxd comes from a pin, baud count from the register file
`timescale 1ns/1ps
module uart_rx_core
	import uart_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// control
	input wire logic [15:0] baud_i,
	input wire logic buffer_read_i,
	input wire logic rxd_i,
	// status
	output logic done_o,
	output logic buffer_full_o,
	output logic [7:0] buffer_o,
	output logic irq_o
);
	logic rxd_meta;
	logic rxd_sync;
	logic [15:0] count;
	logic [3:0] bits;
	logic enable;
	logic [7:0] shift;
	logic [15:0] next_count;
	logic [3:0] next_bits;
	logic next_enable;
	logic [7:0] next_shift;
	logic next_done;
	logic next_full;
	logic [7:0] next_buffer;
	logic next_irq;

	always_comb begin
		next_count = count;
		next_bits = bits;
		next_enable = enable;
		next_shift = shift;
		next_done = done_o;
		next_full = buffer_full_o;
		next_buffer = buffer_o;
		next_irq = 1'b0;
		if (done_o) begin
			if (!buffer_full_o || buffer_read_i) begin
				next_buffer = shift;
				next_full = 1'b1;
				next_done = 1'b0;
			end
		end else begin
			if (buffer_read_i) begin
				next_full = 1'b0;
			end
			if (!enable && !rxd_sync) begin
				next_count = {1'b0, baud_i[15:1]};
				next_bits = RX_BITS;
				next_enable = 1'b1;
			end else if (enable) begin
				if (count != 16'h0000) begin
					next_count = count - 16'h0001;
				end else if (bits != 4'h0) begin
					next_bits = bits - 4'h1;
					next_shift = {rxd_sync, shift[7:1]};
					next_count = baud_i;
				end else begin
					next_irq = 1'b1;
					next_done = 1'b1;
					next_enable = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			count <= 16'h0000;
			bits <= 4'h0;
			enable <= 1'b0;
			shift <= 8'h00;
			done_o <= 1'b0;
			buffer_full_o <= 1'b0;
			buffer_o <= 8'h00;
			irq_o <= 1'b0;
		end else begin
			rxd_meta <= rxd_i;
			rxd_sync <= rxd_meta;
			count <= next_count;
			bits <= next_bits;
			enable <= next_enable;
			shift <= next_shift;
			done_o <= next_done;
			buffer_full_o <= next_full;
			buffer_o <= next_buffer;
			irq_o <= next_irq;
		end
	end

	buffer_copy_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(done_o && !buffer_full_o) |=> buffer_full_o && !done_o && buffer_o == $past(shift))
		else $error("receive buffer copy wrong");
	full_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(!done_o && buffer_read_i) |=> !buffer_full_o)
		else $error("buffer full not cleared by read");
	done_set_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(enable && count == 16'h0000 && bits == 4'h0 && !done_o) |=> done_o && irq_o)
		else $error("receive done not set");
endmodule

// >>> design/uart_top.sv
// uart register file, cpu port and glue to transmit and receive cores
// assumes: cpu strobes are synchronous to clk_i; rxd and cts come from pins
`timescale 1ns/1ps
// Functional notes
// - read data is the selected register while read and select high, else all ones
// - select 0 reads the full 16-bit baud count
// - select 1 reads transmit ready in bit 8
// - select 2 reads buffer full in bit 8, flow enable in bit 0
// - select 3 reads the last received character in the low byte
// - ready-to-send is flow enable and not receive done
// - receiver empty only when neither done nor buffer full
// - reset loads baud 0x1AF and clears frame, request and flow enable
// - writes taken only with write, select and transmitter idle
// - select 0 write replaces baud count, used at next reload
// - select 1 write loads start, eight data and two stop bits, sets request
// - select 2 write sets flow enable from data bit 0
// - while active request clears, shift pulse moves frame right filling ones
// - reset clears transmit counters, flags, interrupt; serial line high
// - idle with request and clear-to-send allowed loads counters and starts
// - at bit time end drive bit 0, pulse shift, count down, reload
// - at last bit drive line high, pulse interrupt one clock, go idle
// - receiver sets done when a character is assembled
// - buffer full set on copy into buffer, cleared by reading select 3
module uart_top
	import uart_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// cpu port
	input wire logic ce_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [1:0] addr_i,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	// events
	output logic rx_empty_o,
	output logic rx_irq_o,
	output logic tx_irq_o,
	// serial line
	input wire logic rxd_i,
	output logic txd_o,
	input wire logic cts_i,
	output logic rts_o
);
	cpu_req_type req;
	status_type st;
	logic [15:0] baud_count;
	logic [10:0] frame;
	logic send_request;
	logic flow_gate_enable;
	logic [15:0] next_baud_count;
	logic [10:0] next_frame;
	logic next_send_request;
	logic next_flow_gate_enable;
	logic cts_meta;
	logic cts_sync;
	logic cts_ok;
	logic tx_active;
	logic tx_shift;
	logic rx_done;
	logic rx_full;
	logic [7:0] rx_data;
	logic write_ok;
	logic buffer_read;

	assign req = '{sel: ce_i, rd: read_i, wr: write_i, addr: addr_i, wdata: data_i};
	assign cts_ok = cts_sync || !flow_gate_enable;
	assign write_ok = req.wr && req.sel && !tx_active;
	assign buffer_read = req.rd && req.sel && req.addr == SEL_RX_BUFFER;

	assign st = '{ready: !tx_active && cts_ok, rx_full: rx_full, flow: flow_gate_enable,
		rx_data: rx_data};

	// cpu read path
	always_comb begin
		if (req.rd && req.sel) begin
			data_o = read_mux(req.addr, baud_count, st);
		end else begin
			data_o = READ_IDLE;
		end
	end

	assign rts_o = flow_gate_enable && !rx_done;
	assign rx_empty_o = !(rx_done || rx_full);

	// register file write
	always_comb begin
		next_baud_count = baud_count;
		next_frame = frame;
		next_send_request = send_request;
		next_flow_gate_enable = flow_gate_enable;
		if (!tx_active) begin
			if (write_ok) begin
				case (req.addr)
					SEL_BAUD: next_baud_count = req.wdata;
					SEL_TX: begin
						next_frame = {2'b11, req.wdata[7:0], 1'b0};
						next_send_request = 1'b1;
					end
					SEL_RX_STATUS: next_flow_gate_enable = req.wdata[0];
					default: next_frame = frame;
				endcase
			end
		end else begin
			next_send_request = 1'b0;
			if (tx_shift) begin
				next_frame = {1'b1, frame[10:1]};
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			baud_count <= BAUD_RESET;
			frame <= 11'h000;
			send_request <= 1'b0;
			flow_gate_enable <= 1'b0;
			cts_meta <= 1'b0;
			cts_sync <= 1'b0;
		end else begin
			baud_count <= next_baud_count;
			frame <= next_frame;
			send_request <= next_send_request;
			flow_gate_enable <= next_flow_gate_enable;
			cts_meta <= cts_i;
			cts_sync <= cts_meta;
		end
	end

	uart_tx_core tx_core (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.baud_i(baud_count),
		.request_i(send_request),
		.cts_ok_i(cts_ok),
		.frame_lsb_i(frame[0]),
		.active_o(tx_active),
		.shift_o(tx_shift),
		.txd_o(txd_o),
		.irq_o(tx_irq_o)
	);

	uart_rx_core rx_core (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.baud_i(baud_count),
		.buffer_read_i(buffer_read),
		.rxd_i(rxd_i),
		.done_o(rx_done),
		.buffer_full_o(rx_full),
		.buffer_o(rx_data),
		.irq_o(rx_irq_o)
	);

	sequence write_tx_s;
		write_ok && req.addr == SEL_TX;
	endsequence

	read_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!(req.rd && req.sel) |-> data_o == 16'hFFFF)
		else $error("idle read bus not all ones");
	read_baud_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(req.rd && req.sel && req.addr == SEL_BAUD) |-> data_o == baud_count)
		else $error("baud read wrong");
	read_ready_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(req.rd && req.sel && req.addr == SEL_TX) |->
		data_o == {7'h00, !tx_active && (cts_sync || !flow_gate_enable), 8'h00})
		else $error("ready read wrong");
	read_status_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(req.rd && req.sel && req.addr == SEL_RX_STATUS) |->
		data_o == {7'h00, rx_full, 7'h00, flow_gate_enable})
		else $error("status read wrong");
	read_buffer_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(req.rd && req.sel && req.addr == SEL_RX_BUFFER) |-> data_o == {8'h00, rx_data})
		else $error("buffer read wrong");
	rts_level_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		rts_o == (flow_gate_enable && !rx_done) && rx_empty_o == !(rx_done || rx_full))
		else $error("rts or empty wrong");
	busy_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(tx_active && req.wr && req.sel && req.addr == SEL_BAUD) |=> $stable(baud_count))
		else $error("write taken while busy");
	frame_load_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		write_tx_s |=> frame == {2'b11, $past(data_i[7:0]), 1'b0} && send_request)
		else $error("frame load wrong");
	flow_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(write_ok && req.addr == SEL_RX_STATUS) |=> flow_gate_enable == $past(data_i[0]))
		else $error("flow enable write wrong");
	request_drop_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tx_active |=> !send_request)
		else $error("request not cleared while active");

	sequence shift_step_s;
		tx_active && tx_shift;
	endsequence

	sequence hold_step_s;
		tx_active && !tx_shift;
	endsequence

	sequence busy_write_s;
		tx_active && req.wr && req.sel;
	endsequence

	baud_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(write_ok && req.addr == SEL_BAUD) |=> baud_count == $past(data_i))
		else $error("baud write wrong");

	frame_shift_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		shift_step_s |=> frame == {1'b1, $past(frame[10:1])})
		else $error("frame shift wrong");

	frame_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		hold_step_s |=> $stable(frame))
		else $error("frame moved without shift");

	ro_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(write_ok && req.addr == SEL_RX_BUFFER) |=> $stable(baud_count) && $stable(frame)
		&& $stable(flow_gate_enable) && $stable(send_request))
		else $error("select 3 write changed state");

	busy_frame_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(busy_write_s and req.addr == SEL_TX) |=> !send_request)
		else $error("frame write taken while busy");

	busy_flow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(busy_write_s and req.addr == SEL_RX_STATUS) |=> $stable(flow_gate_enable))
		else $error("flow write taken while busy");

	no_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(!tx_active && !(req.wr && req.sel)) |=> $stable(baud_count)
		&& $stable(flow_gate_enable))
		else $error("register changed without write");

	read_clear_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(buffer_read && !rx_done) |=> !rx_full)
		else $error("buffer read did not clear full");

	start_gate_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		(!tx_active && send_request && !cts_ok) |=> !tx_active)
		else $error("frame started without clear-to-send");

	line_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!tx_active |-> txd_o)
		else $error("serial line low while idle");

	irq_idle_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
		tx_irq_o |-> !tx_active)
		else $error("transmit interrupt while active");
endmodule

// >>> tb/uart_partner.sv
// partner model: remote serial terminal on the far side of the uart line
// assumes: same clock as the device, bit time given in clocks by the bench
`timescale 1ns/1ps
module uart_partner (
	// clock
	input wire logic clk_i,
	// link setup
	input wire logic [15:0] period_i,
	// serial line
	input wire logic txd_i,
	output logic rxd_o
);
	logic [7:0] last;
	logic frame_ok;
	logic s0;
	logic s1;
	logic s2;
	int count;

	initial begin
		rxd_o = 1'b1;
		last = 8'h00;
		frame_ok = 1'b0;
		count = 0;
	end

	// catch a frame: start low, eight data bits lsb first, two stop bits high
	always begin
		@(negedge txd_i);
		repeat (period_i / 2) @(posedge clk_i);
		s0 = txd_i;
		for (int i = 0; i < 8; i++) begin
			repeat (period_i) @(posedge clk_i);
			last[i] = txd_i;
		end
		repeat (period_i) @(posedge clk_i);
		s1 = txd_i;
		repeat (period_i) @(posedge clk_i);
		s2 = txd_i;
		frame_ok = (s0 === 1'b0) && (s1 === 1'b1) && (s2 === 1'b1);
		count++;
	end

	// send one character: start bit, eight data bits lsb first, one stop bit
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			#2 rxd_o = f[i];
			repeat (period_i - 1) @(posedge clk_i);
		end
	endtask
endmodule

// >>> tb/uart_top_tb.sv
// testbench: cpu register access, transmit and receive through the partner model
// assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
`timescale 1ns/1ps
module uart_top_tb;
	import uart_pkg::*;

	localparam logic [15:0] BAUD_TEST = 16'h0007;

	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ce_i = 1'b0;
	logic read_i = 1'b0;
	logic write_i = 1'b0;
	logic [1:0] addr_i = 2'h0;
	logic [15:0] data_i = 16'h0000;
	logic [15:0] data_o;
	logic rx_empty_o;
	logic rx_irq_o;
	logic tx_irq_o;
	logic rxd;
	logic txd_o;
	logic cts_i = 1'b0;
	logic rts_o;
	int failures = 0;
	int cmp_count = 0;
	int tx_irqs = 0;
	int rx_irqs = 0;

	always #12.5 clk_i = ~clk_i;

	uart_top u_uart_top (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.read_i(read_i),
		.write_i(write_i),
		.addr_i(addr_i),
		.data_i(data_i),
		.data_o(data_o),
		.rx_empty_o(rx_empty_o),
		.rx_irq_o(rx_irq_o),
		.tx_irq_o(tx_irq_o),
		.rxd_i(rxd),
		.txd_o(txd_o),
		.cts_i(cts_i),
		.rts_o(rts_o)
	);

	uart_partner u_partner (
		.clk_i(clk_i),
		.period_i(BAUD_TEST + 16'h0001),
		.txd_i(txd_o),
		.rxd_o(rxd)
	);

	// count clocks with each interrupt high
	always @(posedge clk_i) begin
		if (tx_irq_o === 1'b1)
			tx_irqs++;
		if (rx_irq_o === 1'b1)
			rx_irqs++;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [1:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		#2;
		ce_i = 1'b1;
		read_i = 1'b1;
		addr_i = a;
		#5 chk(data_o, exp);
		@(posedge clk_i);
		#2;
		ce_i = 1'b0;
		read_i = 1'b0;
	endtask

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge clk_i);
		#2;
		ce_i = 1'b1;
		write_i = 1'b1;
		addr_i = a;
		data_i = d;
		@(posedge clk_i);
		#2;
		ce_i = 1'b0;
		write_i = 1'b0;
	endtask

	task automatic wrap_up;
		$display("counts: %0d failures, %0d comparisons", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#100000;
		failures++;
		$display("unexpected at %0t: watchdog expired", $time);
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge clk_i);
		#2 nrst_i = 1'b1;
		chk(data_o, READ_IDLE);
		chk({14'h0000, rts_o, rx_empty_o}, 16'h0001);
		chk({15'h0000, txd_o}, 16'h0001);
		rd(SEL_BAUD, BAUD_RESET);
		rd(SEL_TX, 16'h0100);
		rd(SEL_RX_STATUS, 16'h0000);
		wr(SEL_BAUD, BAUD_TEST);
		rd(SEL_BAUD, BAUD_TEST);
		wr(SEL_RX_BUFFER, 16'hFFFF);
		rd(SEL_BAUD, BAUD_TEST);
		rd(SEL_RX_STATUS, 16'h0000);
		wr(SEL_RX_STATUS, 16'h0001);
		rd(SEL_RX_STATUS, 16'h0001);
		chk({14'h0000, rts_o, rx_empty_o}, 16'h0003);
		rd(SEL_TX, 16'h0000);
		// frame held back while clear-to-send is low
		wr(SEL_TX, 16'h12A5);
		repeat (40) @(posedge clk_i);
		chk({15'h0000, txd_o}, 16'h0001);
		chk(tx_irqs[15:0], 16'h0000);
		#2 cts_i = 1'b1;
		repeat (10) @(posedge clk_i);
		wr(SEL_BAUD, 16'h0030);
		rd(SEL_TX, 16'h0000);
		for (int i = 0; i < 200 && tx_irqs == 0; i++)
			@(posedge clk_i);
		#2 chk({15'h0000, txd_o}, 16'h0001);
		repeat (5) @(posedge clk_i);
		chk(tx_irqs[15:0], 16'h0001);
		chk({8'h00, u_partner.last}, 16'h00A5);
		chk({15'h0000, u_partner.frame_ok}, 16'h0001);
		rd(SEL_BAUD, BAUD_TEST);
		rd(SEL_TX, 16'h0100);
		// receive a character from the partner
		u_partner.send(8'h3C);
		repeat (4) @(posedge clk_i);
		chk(rx_irqs[15:0], 16'h0001);
		chk({14'h0000, rts_o, rx_empty_o}, 16'h0002);
		rd(SEL_RX_STATUS, 16'h0101);
		rd(SEL_RX_BUFFER, 16'h003C);
		rd(SEL_RX_STATUS, 16'h0001);
		chk({14'h0000, rts_o, rx_empty_o}, 16'h0003);
		wrap_up();
	end
endmodule
